// ---- pkg/sipo_latch_pkg.sv ----
// package for the serial-in parallel-out latch block
`default_nettype none
package sipo_latch_pkg;
  localparam int unsigned STAGES = 8;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  localparam logic [7:0] STORE_RESET = 8'h00;

  typedef struct packed {
    logic serial_in;
    logic shift_clock;
    logic storage_clock;
    logic shift_clear_n;
    logic output_enable_n;
  } pins_t;

  // pins start at their idle levels: clocks low, clear and enable inactive
  localparam pins_t      SYNC_RESET  = 5'h03;
  localparam logic [7:0] FLOAT_RESET = 8'h00;

  typedef enum logic [1:0] {
    EDGE_IDLE = 2'b01,
    EDGE_SEEN = 2'b10
  } edge_state_t;
endpackage
`default_nettype wire

// ---- rtl/serial_in_parallel_out_latch8.sv ----
// serial-in parallel-out shift register with three-state storage register
// Function
// (R1) eight-stage shift register feeds an eight-bit storage register driving outputs
// (R2) shift and storage clocks act on rising edges only
// (R3) direct clear forces every shift stage to zero, independent of shift clock
// (R4) common clocks: storage captures pre-edge shift state, lagging one pulse
// (R5) parallel outputs are three-state under a dedicated output enable
// (R6) enable high floats outputs; low drives storage; registers unaffected
// (R7) clear low holds shift register cleared, overriding shifts; storage untouched
// (R8) shift edge loads serial in to first stage, others take previous stage
// (R9) storage edge loads all stages in parallel regardless of clear and enable
// (R10) cascade output always shows last shift stage, ignoring output enable
`default_nettype none
module serial_in_parallel_out_latch8
  import sipo_latch_pkg::*;
(
  input  wire logic       REF_CLK_I,
  input  wire logic       RSTN_I,
  input  wire logic       CLK_EN_I,
  input  wire logic       SERIAL_IN_I,
  input  wire logic       SHIFT_CLOCK_I,
  input  wire logic       STORAGE_CLOCK_I,
  input  wire logic       SHIFT_CLEAR_N_I,
  input  wire logic       OUTPUT_ENABLE_N_I,
  output logic [7:0]      PARALLEL_OUT_O,
  output logic [7:0]      PARALLEL_OE_O,
  output logic            CASCADE_OUT_O
);

  pins_t       meta_r;
  pins_t       meta_nxt;
  pins_t       sync_r;
  pins_t       sync_nxt;
  pins_t       prev_r;
  pins_t       prev_nxt;
  logic [7:0]  shift_r;
  logic [7:0]  shift_nxt;
  logic [7:0]  store_r;
  logic [7:0]  store_nxt;
  logic [7:0]  drive_r;
  logic [7:0]  drive_nxt;
  logic [7:0]  oe_r;
  logic [7:0]  oe_nxt;
  logic        shift_rise;
  logic        store_rise;

  function automatic logic rising(input logic now_v, input logic was_v);
    rising = now_v & ~was_v;
  endfunction

  // one shift step: stage 0 takes the serial bit, the rest move up
  function automatic logic [7:0] shift_step(input logic [7:0] stages_v, input logic bit_v);
    shift_step = {stages_v[6:0], bit_v};
  endfunction

  function automatic logic [7:0] spread_enable(input logic enable_n_v);
    spread_enable = {8{~enable_n_v}};
  endfunction

  // two-flop synchroniser, then previous-value stage for edge detection
  always_comb begin
    meta_nxt.serial_in       = SERIAL_IN_I;
    meta_nxt.shift_clock     = SHIFT_CLOCK_I;
    meta_nxt.storage_clock   = STORAGE_CLOCK_I;
    meta_nxt.shift_clear_n   = SHIFT_CLEAR_N_I;
    meta_nxt.output_enable_n = OUTPUT_ENABLE_N_I;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      // idle pin levels, so release shows no false edge
      meta_r <= SYNC_RESET;
      sync_r <= SYNC_RESET;
      prev_r <= SYNC_RESET;
    end else if (CLK_EN_I) begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
    end
  end

  // edges come from the synchronised copy against its previous sample
  assign shift_rise = rising(sync_r.shift_clock, prev_r.shift_clock);     // [R2]
  assign store_rise = rising(sync_r.storage_clock, prev_r.storage_clock); // [R2]

  // shift group: a held clear wins over any shift edge
  always_comb begin
    shift_nxt = shift_r;
    if (!sync_r.shift_clear_n) begin
      shift_nxt = SHIFT_RESET;                               // [R3] [R7]
    end else if (shift_rise) begin
      shift_nxt = shift_step(shift_r, sync_r.serial_in);     // [R8] [R1]
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      shift_r <= SHIFT_RESET;
    end else if (CLK_EN_I) begin
      shift_r <= shift_nxt;
    end
  end

  // storage group: takes the stages as they stood before this edge
  always_comb begin
    store_nxt = store_r;
    if (store_rise) begin
      store_nxt = shift_r;                                   // [R9] [R4]
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      store_r <= STORE_RESET;
    end else if (CLK_EN_I) begin
      store_r <= store_nxt;
    end
  end

  // output group: pins follow storage, the enable never touches registers
  always_comb begin
    drive_nxt = store_nxt;                                   // [R1]
    oe_nxt    = spread_enable(sync_r.output_enable_n);       // [R5] [R6]
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      drive_r <= STORE_RESET;
      oe_r    <= FLOAT_RESET;
    end else if (CLK_EN_I) begin
      drive_r <= drive_nxt;
      oe_r    <= oe_nxt;
    end
  end

  assign PARALLEL_OUT_O = drive_r;
  assign PARALLEL_OE_O  = oe_r;
  assign CASCADE_OUT_O  = shift_r[7];                        // [R10]

  // shift register checks
  chk_clear_holds_zero: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I) // [R7]
    (CLK_EN_I && !sync_r.shift_clear_n) |=> (shift_r == 8'h00))
    else $error("shift register not cleared");

  chk_clear_wins: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I) // [R3]
    (CLK_EN_I && !sync_r.shift_clear_n && shift_rise) |=> (shift_r == 8'h00))
    else $error("shift edge beat the clear");

  chk_shift_moves: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I) // [R8]
    (CLK_EN_I && sync_r.shift_clear_n && shift_rise) |=>
      (shift_r == {$past(shift_r[6:0]), $past(sync_r.serial_in)}))
    else $error("shift step wrong");

  chk_no_fall_shift: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I) // [R2]
    (CLK_EN_I && sync_r.shift_clear_n && !shift_rise) |=> $stable(shift_r))
    else $error("shift changed without rising edge");

  chk_cascade_shifts: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I) // [R10]
    (CLK_EN_I && sync_r.shift_clear_n && shift_rise) |=> (CASCADE_OUT_O == $past(shift_r[6])))
    else $error("cascade did not take stage six");

  chk_cascade_last: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I) // [R10]
    (CASCADE_OUT_O == shift_r[7]))
    else $error("cascade not last stage");

  // storage register checks
  chk_store_loads: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I) // [R9]
    (CLK_EN_I && store_rise) |=> (store_r == $past(shift_r)))
    else $error("storage load wrong");

  chk_store_stable: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I) // [R2]
    (CLK_EN_I && !store_rise) |=> $stable(store_r))
    else $error("storage changed without edge");

  chk_store_lags: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I) // [R4]
    (CLK_EN_I && store_rise && shift_rise && sync_r.shift_clear_n) |=>
      ((store_r == $past(shift_r)) && (shift_r[7:1] == store_r[6:0])))
    else $error("storage did not lag shift");

  chk_clear_spares_store: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I) // [R7]
    (CLK_EN_I && !sync_r.shift_clear_n && !store_rise) |=> $stable(store_r))
    else $error("clear touched storage");

  // parallel output checks
  chk_out_follows: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I) // [R6]
    (PARALLEL_OUT_O == store_r))
    else $error("outputs differ from storage");

  chk_drive_loads: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I) // [R9]
    (CLK_EN_I && store_rise) |=> (PARALLEL_OUT_O == $past(shift_r)))
    else $error("parallel outputs did not load");

  chk_enable_map: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I) // [R5]
    CLK_EN_I |=> (PARALLEL_OE_O == {8{~$past(sync_r.output_enable_n)}}))
    else $error("output enable wrong");

  chk_oe_uniform: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I) // [R5]
    (PARALLEL_OE_O == 8'h00) || (PARALLEL_OE_O == 8'hff))
    else $error("output enables differ");

  // synchroniser and clock enable checks
  chk_sync_chain: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    CLK_EN_I |=> (sync_r == $past(meta_r)))
    else $error("synchroniser skipped a stage");

  chk_freeze_holds: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    !CLK_EN_I |=> ($stable(shift_r) && $stable(store_r) && $stable(oe_r) && $stable(sync_r)))
    else $error("state moved while clock enable low");

  // main scenarios
  cov_shift: cover property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    shift_rise && sync_r.shift_clear_n);
  cov_store: cover property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    store_rise);
  cov_tied: cover property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    store_rise && shift_rise);
  cov_float: cover property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    PARALLEL_OE_O == 8'h00 ##1 PARALLEL_OE_O == 8'hff);
  cov_resume: cover property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    !CLK_EN_I ##1 CLK_EN_I);

endmodule
`default_nettype wire

// ---- verif/host_model.sv ----
// host model driving the latch pins
`default_nettype none
module host_model
  import sipo_latch_pkg::*;
(
  output var pins_t pins_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pins_o = 5'h03;
  // one 160 ns link clock cycle, clocks high for the last 80 ns, data set 80 ns ahead of the rise
  task automatic pulse(input logic sh, input logic st, input logic d);
    pins_o.serial_in = d;
    #80;
    pins_o.shift_clock = sh;
    pins_o.storage_clock = st;
    #80;
    pins_o.shift_clock = 1'b0;
    pins_o.storage_clock = 1'b0;
  endtask
  task automatic levels(input logic oe_n, input logic clr_n);
    pins_o.output_enable_n = oe_n;
    pins_o.shift_clear_n = clr_n;
    #80;
  endtask
endmodule
`default_nettype wire

// ---- verif/serial_in_parallel_out_latch8_test.sv ----
// testbench for the serial-in parallel-out latch
`default_nettype none
module serial_in_parallel_out_latch8_test
  import sipo_latch_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       clk_en = 1'b1;
  pins_t      pins;
  logic [7:0] pout;
  logic [7:0] poe;
  logic       cout;
  int         errors = 0;
  int         num_checks = 0;
  localparam logic [7:0] PAT = 8'hA5;
  always #10 clk = ~clk;
  host_model host_model_i (.pins_o(pins));
  serial_in_parallel_out_latch8 serial_in_parallel_out_latch8_i (
    .REF_CLK_I(clk), .RSTN_I(rstn), .CLK_EN_I(clk_en),
    .SERIAL_IN_I(pins.serial_in), .SHIFT_CLOCK_I(pins.shift_clock),
    .STORAGE_CLOCK_I(pins.storage_clock), .SHIFT_CLEAR_N_I(pins.shift_clear_n),
    .OUTPUT_ENABLE_N_I(pins.output_enable_n),
    .PARALLEL_OUT_O(pout), .PARALLEL_OE_O(poe), .CASCADE_OUT_O(cout));
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // first bit sent ends on the cascade pin
  task automatic t_shift;
    host_model_i.levels(1'b0, 1'b1);
    for (int i = 7; i >= 0; i--) host_model_i.pulse(1'b1, 1'b0, PAT[i]);
    check({poe, cout, pout}, 17'h1_FF00);
    host_model_i.pulse(1'b0, 1'b1, 1'b0);
    check({poe, cout, pout}, 17'h1_FFA5);
  endtask
  // clear holds shift stages, storage kept
  task automatic t_clear;
    host_model_i.levels(1'b0, 1'b0);
    host_model_i.pulse(1'b1, 1'b0, 1'b1);
    check({poe, cout, pout}, 17'h1_FEA5);
    host_model_i.levels(1'b0, 1'b1);
    host_model_i.pulse(1'b0, 1'b1, 1'b0);
    check({poe, cout, pout}, 17'h1_FE00);
  endtask
  // tied clocks with outputs floated
  task automatic t_tied;
    host_model_i.levels(1'b1, 1'b1);
    check({poe, cout, pout}, 17'h0_0000);
    for (int i = 0; i < 8; i++) host_model_i.pulse(1'b1, 1'b1, 1'b1);
    check({8'h00, poe, cout}, 17'h0_0001);
    host_model_i.levels(1'b0, 1'b1);
    check({poe, cout, pout}, 17'h1_FF7F);
  endtask
  // clock enable low freezes everything, pulses included
  task automatic t_freeze;
    clk_en = 1'b0;
    host_model_i.pulse(1'b1, 1'b1, 1'b0);
    check({poe, cout, pout}, 17'h1_FF7F);
    clk_en = 1'b1;
    host_model_i.pulse(1'b1, 1'b1, 1'b0);
    check({poe, cout, pout}, 17'h1_FFFF);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1 rstn = 1'b1;
    @(posedge clk);
    #1;
    t_shift;
    t_clear;
    t_tied;
    t_freeze;
    tally_and_finish;
  end
  initial begin
    #50us;
    errors++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
